// File: core/ofs_pkg.sv
package ofs_pkg;

   // ---------------------------------------------
   // sizes
   // ---------------------------------------------
   localparam int NTERM = 4; // output terminals
   localparam int NCFG = 16; // config words
   localparam int CODE_W = 9; // setting code width
   localparam int FN_W = 5; // function id width

   // ---------------------------------------------
   // register byte offsets
   // ---------------------------------------------
   localparam logic [7:0] A_CODE0 = 8'h00; // codes 0x00..0x0c
   localparam logic [7:0] A_START = 8'h10; // starting frequency
   localparam logic [7:0] A_FWD_THR = 8'h14; // forward freq threshold
   localparam logic [7:0] A_REV_THR = 8'h18; // reverse freq threshold
   localparam logic [7:0] A_REGEN_LIM = 8'h1C; // regen duty limit
   localparam logic [7:0] A_THERM_TRIP = 8'h20; // thermal trip level
   localparam logic [7:0] A_CUR_HI = 8'h24; // current high threshold
   localparam logic [7:0] A_CUR_HI_MS = 8'h28; // high dwell, ms
   localparam logic [7:0] A_CUR_LO = 8'h2C; // current low threshold
   localparam logic [7:0] A_CUR_LO_MS = 8'h30; // low dwell, ms
   localparam logic [7:0] A_PID_LOW = 8'h34; // loop lower limit
   localparam logic [7:0] A_PID_HIGH = 8'h38; // loop upper limit
   localparam logic [7:0] A_FILTER = 8'h3C; // output filter, ms
   localparam logic [7:0] A_STATE = 8'h40; // terminal levels, ro
   localparam logic [7:0] A_IRQ_ST = 8'h44; // sticky events, w1c
   localparam logic [7:0] A_IRQ_MASK = 8'h48; // interrupt mask

   // ---------------------------------------------
   // reset values
   // ---------------------------------------------
   localparam logic [15:0] RST_CODE0 = 16'h0000; // running
   localparam logic [15:0] RST_CODE1 = 16'h0001; // at speed
   localparam logic [15:0] RST_CODE2 = 16'h0004; // freq detect
   localparam logic [15:0] RST_CODE3 = 16'h000B; // ready
   localparam logic [15:0] RST_ZERO = 16'h0000; // thresholds
   localparam logic [15:0] RST_FILTER = 16'h270F; // 9999, off
   localparam logic [NTERM-1:0] RST_MASK = 4'h0; // all masked

   // ---------------------------------------------
   // code ranges and figures
   // ---------------------------------------------
   localparam int CODE_SPAN = 100; // codes per logic range
   localparam int CODE_MAX = 399; // highest legal code
   localparam logic [15:0] FILT_OFF = 16'h270F; // 9999
   localparam logic [15:0] FILT_MIN = 16'h0005; // 5 ms
   localparam logic [15:0] FILT_MAX = 16'h0032; // 50 ms
   localparam int PRE_PCT = 85; // pre-alarm percent
   localparam int FULL_PCT = 100; // trip percent

   // ---------------------------------------------
   // timing
   // ---------------------------------------------
   localparam int CLK_PS = 8000; // 125 MHz period
   localparam int MS_PS = 1000000000; // one millisecond
   localparam int CYC_PER_MS = MS_PS / CLK_PS;

   // ---------------------------------------------
   // function ids
   // ---------------------------------------------
   localparam int FN_RUN = 0;
   localparam int FN_SU = 1;
   localparam int FN_OL = 3;
   localparam int FN_FU = 4;
   localparam int FN_RBP = 7;
   localparam int FN_THP = 8;
   localparam int FN_RY = 11;
   localparam int FN_CUR_HI = 12;
   localparam int FN_CUR_ZERO = 13;
   localparam int FN_PID_LO = 14;
   localparam int FN_PID_HI = 15;
   localparam int FN_PID_FWD = 16;
   localparam int FN_BYP_A = 18;
   localparam int FN_BYP_B = 19;
   localparam int FN_BRAKE = 20;
   localparam int FN_STROKE = 24;

   // ---------------------------------------------
   // carriers
   // ---------------------------------------------
   typedef struct packed {
      logic running; // output stage operating
      logic reverse; // reverse rotation
      logic [15:0] out_freq; // output frequency
      logic [15:0] set_freq; // commanded frequency
      logic stall_active; // stall prevention working
      logic [15:0] regen_duty; // regen brake duty
      logic [15:0] therm_accum; // thermal accumulator
      logic init_done; // power-on reset done
      logic start_ready; // ready with start on
      logic [15:0] out_current; // output current
      logic [15:0] pid_value; // process loop input
      logic pid_run; // loop control active
      logic pid_forward; // loop drives forward
      logic bypass_a; // bypass contactor a cmd
      logic bypass_b; // bypass contactor b cmd
      logic brake_seq_en; // brake sequence enabled
      logic brake_open; // brake sequence open cmd
   } ofs_drive_t;

   typedef struct packed {
      logic valid; // code selects a function
      logic invert; // negative logic range
      logic [FN_W-1:0] fn; // function id
   } ofs_sel_t;

endpackage

// File: core/ofs_selector.sv
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module ofs_selector #(
   parameter int CYC_PER_MS = ofs_pkg::CYC_PER_MS
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire ofs_pkg::ofs_drive_t drv,
   input wire logic fwd_stroke_end_pin,
   input wire logic rev_stroke_end_pin,
   output logic [ofs_pkg::NTERM-1:0] term_out,
   output logic irq
);

   // ---------------------------------------------
   // functions
   // ---------------------------------------------

   // mapped word address check
   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a[1:0] == 2'b00) && (a <= ofs_pkg::A_IRQ_MASK);
   endfunction

   // split a setting code into function and polarity
   function automatic ofs_pkg::ofs_sel_t decode(input logic [15:0] c);
      ofs_pkg::ofs_sel_t s;
      int v;
      int f;
      v = int'(c);
      f = v % ofs_pkg::CODE_SPAN;
      s.fn = f[ofs_pkg::FN_W-1:0];
      s.invert = ((v / ofs_pkg::CODE_SPAN) % 2) == 1;
      s.valid = v <= ofs_pkg::CODE_MAX;
      case (f)
         ofs_pkg::FN_RUN, ofs_pkg::FN_SU, ofs_pkg::FN_OL,
         ofs_pkg::FN_FU, ofs_pkg::FN_RBP, ofs_pkg::FN_THP,
         ofs_pkg::FN_RY, ofs_pkg::FN_CUR_HI,
         ofs_pkg::FN_CUR_ZERO, ofs_pkg::FN_PID_LO,
         ofs_pkg::FN_PID_HI, ofs_pkg::FN_PID_FWD,
         ofs_pkg::FN_BRAKE, ofs_pkg::FN_STROKE: begin
            s.valid = s.valid;
         end
         ofs_pkg::FN_BYP_A, ofs_pkg::FN_BYP_B: begin
            s.valid = s.valid && !s.invert;
         end
         default: begin
            s.valid = 1'b0;
         end
      endcase
      if (f >= 32) begin
         s.valid = 1'b0;
      end
      decode = s;
   endfunction

   // value at or above 85 percent of a limit
   function automatic logic pre_reached(input logic [15:0] val,
                                        input logic [15:0] lim);
      logic [23:0] lhs;
      logic [23:0] rhs;
      lhs = 24'(val) * 24'(ofs_pkg::FULL_PCT);
      rhs = 24'(lim) * 24'(ofs_pkg::PRE_PCT);
      pre_reached = (lim != 16'h0000) && (lhs >= rhs);
   endfunction

   // ---------------------------------------------
   // declarations
   // ---------------------------------------------
   localparam int NT = ofs_pkg::NTERM;
   logic [15:0] cfg_q [ofs_pkg::NCFG]; // config words
   logic [NT-1:0] term_q; // filtered terminal levels
   logic [NT-1:0] irq_st_q; // sticky change events
   logic [NT-1:0] irq_mask_q; // interrupt enables
   logic irq_q; // interrupt line
   logic awready_q; // address channel open
   logic wready_q; // data channel open
   logic aw_have_q; // address held
   logic w_have_q; // data held
   logic [7:0] aw_addr_q; // held write address
   logic [31:0] w_data_q; // held write data
   logic [3:0] w_strb_q; // held byte enables
   logic bvalid_q; // write answer pending
   logic [1:0] bresp_q; // write answer code
   logic arready_q; // read address open
   logic rvalid_q; // read answer pending
   logic [31:0] rdata_q; // read data
   logic [1:0] rresp_q; // read answer code
   logic wr_fire; // write performed this edge
   logic [3:0] wr_idx; // config index written
   logic [1:0] fsync_q; // forward stroke sync
   logic [1:0] rsync_q; // reverse stroke sync
   logic [31:0] ms_cnt_q; // millisecond prescaler
   logic ms_tick_q; // one-cycle ms strobe
   logic [15:0] hi_ms_q; // dwell above threshold
   logic [15:0] lo_ms_q; // dwell below threshold
   logic cur_above; // current above threshold
   logic cur_below; // current below threshold
   logic [31:0] cond; // status by function id
   logic [15:0] filt_ms; // effective filter time
   logic filt_off; // filter disabled

   // ---------------------------------------------
   // outputs
   // ---------------------------------------------
   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;
   assign term_out = term_q;
   assign irq = irq_q;

   // ---------------------------------------------
   // write channel
   // ---------------------------------------------
   assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
   assign wr_idx = aw_addr_q[5:2];

   // address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= 2'b00;
      end else begin
         // capture address
         if (awvalid && awready_q) begin
            awready_q <= 1'b0;
            aw_have_q <= 1'b1;
            aw_addr_q <= awaddr;
         end
         // capture data
         if (wvalid && wready_q) begin
            wready_q <= 1'b0;
            w_have_q <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
         end
         // answer once both are held
         if (wr_fire) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= addr_ok(aw_addr_q) ? 2'b00 : 2'b10;
         end
         // reopen after the answer is taken
         if (bvalid_q && bready) begin
            bvalid_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
         end
      end
   end

   // config words, low two byte lanes only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_q[0] <= ofs_pkg::RST_CODE0;
         cfg_q[1] <= ofs_pkg::RST_CODE1;
         cfg_q[2] <= ofs_pkg::RST_CODE2;
         cfg_q[3] <= ofs_pkg::RST_CODE3;
         for (int i = 4; i < ofs_pkg::NCFG - 1; i++) begin
            cfg_q[i] <= ofs_pkg::RST_ZERO;
         end
         cfg_q[ofs_pkg::NCFG-1] <= ofs_pkg::RST_FILTER;
      end else if (wr_fire && addr_ok(aw_addr_q) &&
                   aw_addr_q < ofs_pkg::A_STATE) begin
         if (w_strb_q[0]) begin
            cfg_q[wr_idx][7:0] <= w_data_q[7:0];
         end
         if (w_strb_q[1]) begin
            cfg_q[wr_idx][15:8] <= w_data_q[15:8];
         end
      end
   end

   // mask register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_mask_q <= ofs_pkg::RST_MASK;
      end else if (wr_fire && aw_addr_q == ofs_pkg::A_IRQ_MASK &&
                   w_strb_q[0]) begin
         irq_mask_q <= w_data_q[NT-1:0];
      end
   end

   // ---------------------------------------------
   // read channel
   // ---------------------------------------------

   // one read at a time, data one edge after address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= 2'b00;
      end else begin
         if (arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= addr_ok(araddr) ? 2'b00 : 2'b10;
            rdata_q <= 32'h0000_0000;
            // config words
            if (addr_ok(araddr) && araddr < ofs_pkg::A_STATE) begin
               rdata_q[15:0] <= cfg_q[araddr[5:2]];
            end
            // live state, sticky events and mask
            if (araddr == ofs_pkg::A_STATE) begin
               rdata_q[NT-1:0] <= term_q;
            end
            if (araddr == ofs_pkg::A_IRQ_ST) begin
               rdata_q[NT-1:0] <= irq_st_q;
            end
            if (araddr == ofs_pkg::A_IRQ_MASK) begin
               rdata_q[NT-1:0] <= irq_mask_q;
            end
         end
         if (rvalid_q && rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
         end
      end
   end

   // ---------------------------------------------
   // pin synchronisers
   // ---------------------------------------------

   // stroke end inputs come from terminals
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fsync_q <= 2'b00;
         rsync_q <= 2'b00;
      end else begin
         fsync_q <= {fsync_q[0], fwd_stroke_end_pin};
         rsync_q <= {rsync_q[0], rev_stroke_end_pin};
      end
   end

   // ---------------------------------------------
   // millisecond time base
   // ---------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ms_cnt_q <= 32'h0000_0000;
         ms_tick_q <= 1'b0;
      end else if (ms_cnt_q >= 32'(CYC_PER_MS - 1)) begin
         ms_cnt_q <= 32'h0000_0000;
         ms_tick_q <= 1'b1;
      end else begin
         ms_cnt_q <= ms_cnt_q + 32'h0000_0001;
         ms_tick_q <= 1'b0;
      end
   end

   // ---------------------------------------------
   // current dwell timers
   // ---------------------------------------------
   assign cur_above = drv.out_current > cfg_q[9];
   assign cur_below = drv.out_current < cfg_q[11];

   always_ff @(posedge aclk) begin
      if (!aresetn || !cur_above) begin
         hi_ms_q <= 16'h0000;
      end else if (ms_tick_q && hi_ms_q != 16'hFFFF) begin
         hi_ms_q <= hi_ms_q + 16'h0001;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || !cur_below) begin
         lo_ms_q <= 16'h0000;
      end else if (ms_tick_q && lo_ms_q != 16'hFFFF) begin
         lo_ms_q <= lo_ms_q + 16'h0001;
      end
   end

   // ---------------------------------------------
   // status conditions by function id
   // ---------------------------------------------
   always_comb begin
      cond = 32'h0000_0000;
      cond[ofs_pkg::FN_RUN] = drv.running &&
                              drv.out_freq >= cfg_q[4];
      cond[ofs_pkg::FN_SU] = drv.running &&
                             drv.out_freq == drv.set_freq;
      cond[ofs_pkg::FN_OL] = drv.stall_active;
      cond[ofs_pkg::FN_FU] = drv.reverse ?
                             drv.out_freq >= cfg_q[6] :
                             drv.out_freq >= cfg_q[5];
      cond[ofs_pkg::FN_RBP] = pre_reached(drv.regen_duty, cfg_q[7]);
      cond[ofs_pkg::FN_THP] = pre_reached(drv.therm_accum,
                                          cfg_q[8]);
      cond[ofs_pkg::FN_RY] = drv.init_done &&
                             (drv.start_ready || drv.running);
      cond[ofs_pkg::FN_CUR_HI] = cur_above && hi_ms_q >= cfg_q[10];
      cond[ofs_pkg::FN_CUR_ZERO] = cur_below &&
                                   lo_ms_q >= cfg_q[12];
      cond[ofs_pkg::FN_PID_LO] = drv.pid_run &&
                                 drv.pid_value < cfg_q[13];
      cond[ofs_pkg::FN_PID_HI] = drv.pid_run &&
                                 drv.pid_value > cfg_q[14];
      cond[ofs_pkg::FN_PID_FWD] = drv.pid_run && drv.pid_forward;
      cond[ofs_pkg::FN_BYP_A] = drv.bypass_a;
      cond[ofs_pkg::FN_BYP_B] = drv.bypass_b;
      cond[ofs_pkg::FN_BRAKE] = drv.brake_seq_en && drv.brake_open;
      cond[ofs_pkg::FN_STROKE] = fsync_q[1] || rsync_q[1];
   end

   // ---------------------------------------------
   // filter time
   // ---------------------------------------------

   // clamp to 5..50 ms, 9999 bypasses
   always_comb begin
      filt_off = cfg_q[15] == ofs_pkg::FILT_OFF;
      filt_ms = cfg_q[15];
      if (cfg_q[15] < ofs_pkg::FILT_MIN) begin
         filt_ms = ofs_pkg::FILT_MIN;
      end else if (cfg_q[15] > ofs_pkg::FILT_MAX) begin
         filt_ms = ofs_pkg::FILT_MAX;
      end
   end

   // ---------------------------------------------
   // per-terminal selection and filter
   // ---------------------------------------------
   for (genvar t = 0; t < NT; t++) begin : g_term
      ofs_pkg::ofs_sel_t sel; // decoded code
      logic raw; // unfiltered level
      logic [15:0] hold_q; // ms pending change stable

      assign sel = decode(cfg_q[t]);

      assign raw = sel.valid ? (cond[sel.fn] ^ sel.invert) : 1'b0;

      // change only after stable filter time
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            term_q[t] <= 1'b0;
            hold_q <= 16'h0000;
         end else if (filt_off || !sel.valid) begin
            term_q[t] <= raw;
            hold_q <= 16'h0000;
         end else if (raw == term_q[t]) begin
            hold_q <= 16'h0000;
         end else if (hold_q >= filt_ms) begin
            term_q[t] <= raw;
            hold_q <= 16'h0000;
         end else if (ms_tick_q) begin
            hold_q <= hold_q + 16'h0001;
         end
      end

      // change event sticks; set wins over clear
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            irq_st_q[t] <= 1'b0;
         end else if (term_q[t] != raw &&
                      (filt_off || !sel.valid ||
                       hold_q >= filt_ms)) begin
            irq_st_q[t] <= 1'b1;
         end else if (wr_fire && aw_addr_q == ofs_pkg::A_IRQ_ST &&
                      w_strb_q[0] && w_data_q[t]) begin
            irq_st_q[t] <= 1'b0;
         end
      end
   end

   // ---------------------------------------------
   // interrupt line
   // ---------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(irq_st_q & irq_mask_q);
      end
   end

endmodule
`default_nettype wire

// File: dv/ofs_field_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// limit switches on the machine, normally open, high = on
// ----
module ofs_field_model (
   input wire logic aclk,
   input wire logic [1:0] sw_cmd,
   output logic fwd_pin,
   output logic rev_pin
);
   // contacts settle a few ns after the bench moves them
   always @(posedge aclk) begin
      fwd_pin <= #3 sw_cmd[0];
      rev_pin <= #3 sw_cmd[1];
   end
endmodule
`default_nettype wire

// File: dv/ofs_selector_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ofs_selector_monitor #(
   parameter int CYC_PER_MS = 10
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] araddr,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [ofs_pkg::NTERM-1:0] term_out,
   input wire logic irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ----
   // bus handshakes
   // ----
   sequence s_wr_take;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence s_rd_take;
      arvalid && arready;
   endsequence
   property p_wr_resp; s_wr_take |-> ##[1:2] bvalid; endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("no write response");
   property p_wr_block; bvalid |-> !awready && !wready; endproperty
   a_wr_block: assert property (p_wr_block) else $error("write not blocked");
   property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_wr_free; bvalid && bready |=> awready && wready; endproperty
   a_wr_free: assert property (p_wr_free) else $error("write not reopened");
   property p_rd_resp; s_rd_take |=> rvalid && !arready; endproperty
   a_rd_resp: assert property (p_rd_resp) else $error("no read data");
   property p_r_hold;
      rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_rd_err;
      s_rd_take ##0 (araddr > ofs_pkg::A_IRQ_MASK || araddr[1:0] != 2'b00)
         |=> rresp == 2'b10 && rdata == 32'h0000_0000;
   endproperty
   a_rd_err: assert property (p_rd_err) else $error("bad read not refused");
   property p_rd_ok;
      s_rd_take ##0 (araddr <= ofs_pkg::A_IRQ_MASK && araddr[1:0] == 2'b00)
         |=> rresp == 2'b00 && rdata[31:16] == 16'h0000;
   endproperty
   a_rd_ok: assert property (p_rd_ok) else $error("good read refused");
   // terminals idle just after reset
   property p_rst; $rose(aresetn) |-> term_out == '0 && !irq; endproperty
   a_rst: assert property (p_rst) else $error("outputs not idle at reset");
endmodule
bind ofs_selector ofs_selector_monitor #(.CYC_PER_MS(CYC_PER_MS)) u_mon (
   .aclk, .aresetn, .araddr, .awvalid, .awready, .wvalid, .wready, .bresp,
   .bvalid, .bready, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
   .term_out, .irq);
`default_nettype wire

// File: dv/ofs_selector_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ofs_selector_tb;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
   logic irq, fwd_pin, rev_pin;
   logic [7:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, r = 32'h60f1_1409;
   logic [1:0] bresp, rresp, sw = '0;
   logic [ofs_pkg::NTERM-1:0] term_out, ev;
   ofs_pkg::ofs_drive_t drv = '0, d;
   int miscompares = 0, check_count = 0, cyc = 0;
   int tc[4] = '{0, 1, 4, 11};
   int th[11] = '{2, 2, 1, 20, 20, 2, 0, 1, 0, 1, 2};
   int cl[$] = '{0, 1, 3, 4, 7, 8, 11, 12, 13, 14, 15, 16, 18, 19, 20, 24, 2,
      21, 400};
   always #4 aclk = ~aclk;
   ofs_selector #(.CYC_PER_MS(10)) u_ofs_selector (.aclk, .aresetn, .awaddr,
      .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp,
      .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .drv, .fwd_stroke_end_pin(fwd_pin),
      .rev_stroke_end_pin(rev_pin), .term_out, .irq);
   ofs_field_model u_ofs_field_model (.aclk, .sw_cmd(sw), .fwd_pin, .rev_pin);
   // ----
   // helpers
   // ----
   task automatic report_and_stop;
      if (miscompares == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         miscompares++;
         $display("[ERR] %0t seen %h exp %h", $time, s, e);
      end
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         miscompares++;
         report_and_stop;
      end
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] x);
      @(posedge aclk);
      awaddr <= a;
      wdata <= x;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      chk(32'(bresp), 32'h0000_0000);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      chk(rdata, e);
   endtask
   // reference terminal level for one code
   function automatic logic fx(int c, ofs_pkg::ofs_drive_t q, logic [1:0] s);
      int f;
      logic t;
      f = c % 100;
      if (c > 399 || (c / 100 % 2 == 1 && (f == 18 || f == 19))) return 1'b0;
      case (f)
         0: t = q.running && q.out_freq >= th[0];
         1: t = q.running && q.out_freq == q.set_freq;
         3: t = q.stall_active;
         4: t = q.out_freq >= (q.reverse ? th[2] : th[1]);
         7: t = q.regen_duty * 100 >= th[3] * 85;
         8: t = q.therm_accum * 100 >= th[4] * 85;
         11: t = q.init_done && (q.start_ready || q.running);
         12: t = q.out_current > th[5];
         13: t = q.out_current < th[7];
         14: t = q.pid_run && q.pid_value < th[9];
         15: t = q.pid_run && q.pid_value > th[10];
         16: t = q.pid_run && q.pid_forward;
         18: t = q.bypass_a;
         19: t = q.bypass_b;
         20: t = q.brake_seq_en && q.brake_open;
         24: t = s != 2'b00;
         default: return 1'b0;
      endcase
      return t ^ (c / 100 % 2 == 1);
   endfunction
   // one shift of the random source
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // random drive status and switches, then compare all terminals
   task automatic step;
      repeat (96) r = lfsr(r);
      d = ofs_pkg::ofs_drive_t'({r, r ^ 32'h5a5a_0f0f, r << 3, r[10:0]});
      d.out_freq &= 16'h0003;
      d.set_freq &= 16'h0003;
      d.regen_duty &= 16'h001F;
      d.therm_accum &= 16'h001F;
      d.out_current &= 16'h0003;
      d.pid_value &= 16'h0003;
      @(posedge aclk);
      drv <= d;
      sw <= r[30:29];
      repeat (7) @(posedge aclk);
      for (int k = 0; k < 4; k++) ev[k] = fx(tc[k], d, r[30:29]);
      chk(32'(term_out), 32'(ev));
   endtask
   // ----
   // main sequence
   // ----
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd(ofs_pkg::A_CODE0 + 8'h0C, 32'h0000_000B);
      rd(ofs_pkg::A_FILTER, 32'h0000_270F);
      rd(8'h4C, 32'h0000_0000);
      for (int i = 0; i < 11; i++) wr(8'h10 + 8'(4 * i), 32'(th[i]));
      foreach (cl[i]) begin
         for (int n = 0; n < 2; n++) begin
            tc[0] = cl[i] + 100 * n + 200 * (i % 2);
            tc[1] = cl[(i + 1) % 16];
            wr(ofs_pkg::A_CODE0, 32'(tc[0]));
            wr(ofs_pkg::A_CODE0 + 8'h04, 32'(tc[1]));
            repeat (5) step;
         end
      end
      // interrupt on a terminal change, enabled in the mask and cleared
      tc[0] = 24;
      wr(ofs_pkg::A_CODE0, 32'd24);
      wr(ofs_pkg::A_IRQ_MASK, 32'h0000_0001);
      wr(ofs_pkg::A_IRQ_ST, 32'h0000_000F);
      repeat (3) @(posedge aclk);
      chk(32'(irq), 32'h0000_0000);
      sw <= {1'b0, ~|sw};
      repeat (7) @(posedge aclk);
      chk(32'(irq), 32'h0000_0001);
      rd(ofs_pkg::A_IRQ_ST, 32'h0000_0001);
      wr(ofs_pkg::A_IRQ_ST, 32'h0000_0001);
      repeat (3) @(posedge aclk);
      chk(32'(irq), 32'h0000_0000);
      // output filter holds a change for five milliseconds
      sw <= 2'b00;
      wr(ofs_pkg::A_FILTER, 32'h0000_0005);
      repeat (80) @(posedge aclk);
      sw <= 2'b10;
      repeat (30) @(posedge aclk);
      chk(32'(term_out[0]), 32'h0000_0000);
      repeat (45) @(posedge aclk);
      chk(32'(term_out[0]), 32'h0000_0001);
      // current must stay above threshold for the dwell time
      drv.out_current <= 16'h0000;
      wr(ofs_pkg::A_FILTER, 32'h0000_270F);
      wr(ofs_pkg::A_CUR_HI_MS, 32'h0000_0003);
      wr(ofs_pkg::A_CODE0, 32'd12);
      drv.out_current <= 16'h0003;
      repeat (15) @(posedge aclk);
      chk(32'(term_out[0]), 32'h0000_0000);
      repeat (25) @(posedge aclk);
      chk(32'(term_out[0]), 32'h0000_0001);
      report_and_stop;
   end
endmodule
`default_nettype wire
